// File: hdl/psrb_relay_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - sixty-four free user relay bits, no system meaning
// - user parameters 506..515 map onto free data words 100..119
// - self-diagnostic error flag set when diagnosis finds an error
// - live operation error flag follows the error condition
// - sticky operation error flag holds until explicitly cleared
// - one flag always one, another always zero
// - first-scan pulse high for exactly one scan after run
// - inverted first-scan flag low for exactly one scan after run
// - first-scan flags pulse only outside stop; levels follow stop/run
// - forward and reverse start bits drive the start terminals
// - speed, inch, second function, current input bits drive terminals
// - shutoff, self-hold, changeover bits drive their terminals
// - reset control bit drives the drive reset terminal
// - eleven virtual output bits mirror the assigned output functions
// - virtual outputs update without an output card fitted
// - source select: control word bits when clear, terminal word when set
// - source selection switches all twelve terminal bits together
// - error step word captured only on sticky flag rising
module psrb_relay_bank
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // engine events, same clock
   input wire logic diag_error,
   input wire logic instr_error,
   input wire logic [15:0] instr_error_step,
   // drive status pins, asynchronous
   input wire logic [8:0] drive_status_in,
   input wire logic [10:0] virtual_out_in,
   // drive input terminals
   output logic forward_start,
   output logic reverse_start,
   output logic speed_sel_high,
   output logic speed_sel_mid,
   output logic speed_sel_low,
   output logic inch_mode_sel,
   output logic second_function_sel,
   output logic current_input_sel,
   output logic changeover_sel,
   output logic output_shutoff,
   output logic self_hold_sel,
   output logic drive_reset_in,
   // system flags
   output logic self_diag_error_flag,
   output logic live_op_error_flag,
   output logic sticky_op_error_flag,
   output logic always_one_flag,
   output logic always_zero_flag,
   output logic first_scan_pulse,
   output logic first_scan_pulse_n
);
   import psrb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // byte-lane merge for 32-bit writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [19:0] stat_meta_reg, stat_meta_next;
   logic [19:0] stat_sync_reg, stat_sync_next;
   logic [19:0] stat_scan_reg, stat_scan_next;

   always_comb
   begin
      stat_meta_next = {virtual_out_in, drive_status_in};
      stat_sync_next = stat_meta_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // bus state

   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic rd_mem_reg, rd_mem_next;
   logic [31:0] relay_lo_reg, relay_lo_next;
   logic [31:0] relay_hi_reg, relay_hi_next;
   logic [12:0] ctrl_reg, ctrl_next;
   logic [15:0] term_word_reg, term_word_next;
   logic run_reg, run_next;
   logic live_reg, live_next;
   logic sticky_reg, sticky_next;
   logic diag_reg, diag_next;
   logic [15:0] step_reg, step_next;
   logic fsp_reg, fsp_next;
   logic fsp_done_reg, fsp_done_next;
   logic [11:0] term_reg, term_next;
   logic req;
   logic wr;
   logic scan_end;
   logic mem_hit;
   logic [7:0] mem_off;
   logic [31:0] wmask;
   logic [15:0] mem_rdata;

   assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr = req & wb_we_i;
   assign mem_off = wb_adr_i - PSRB_ADDR_DATA_BASE;
   assign mem_hit = (wb_adr_i >= PSRB_ADDR_DATA_BASE)
      && (mem_off[7:2] < 6'(PSRB_DATA_WORDS)) && (wb_adr_i[1:0] == 2'h0);
   assign wmask = wb_dat_i;
   assign scan_end = wr && (wb_adr_i == PSRB_ADDR_RUN) && wb_sel_i[0]
      && wb_dat_i[PSRB_SCAN_END_BIT];

   // user data words, free for program use
   psrb_data_mem u_mem
   (
      .ref_clk(ref_clk),
      .we(wr & mem_hit & (&wb_sel_i[1:0])),
      .addr(mem_off[PSRB_DATA_AW+1:2]),
      .wdata(wb_dat_i[15:0]),
      .rdata(mem_rdata)
   );

   // register writes and flag updates
   always_comb
   begin
      relay_lo_next = relay_lo_reg;
      relay_hi_next = relay_hi_reg;
      ctrl_next = ctrl_reg;
      term_word_next = term_word_reg;
      run_next = run_reg;
      fsp_next = fsp_reg;
      fsp_done_next = fsp_done_reg;
      stat_scan_next = stat_scan_reg;
      if (wr)
      begin
         case (wb_adr_i)
            PSRB_ADDR_RELAY_LO: relay_lo_next = lane_merge(relay_lo_reg, wmask, wb_sel_i);
            PSRB_ADDR_RELAY_HI: relay_hi_next = lane_merge(relay_hi_reg, wmask, wb_sel_i);
            PSRB_ADDR_CTRL: ctrl_next = 13'(lane_merge(32'(ctrl_reg), wmask, wb_sel_i));
            PSRB_ADDR_TERM_WORD: term_word_next = 16'(lane_merge(32'(term_word_reg), wmask,
               wb_sel_i));
            PSRB_ADDR_RUN:
            begin
               if (wb_sel_i[0])
               begin
                  run_next = wb_dat_i[PSRB_RUN_BIT];
               end
            end
            default:
            begin
            end
         endcase
      end
      // first scan: high from run entry until first scan end
      if (!run_next)
      begin
         fsp_next = 1'b0; // stopped: pulse flags rest at stop levels
         fsp_done_next = 1'b0;
      end
      else if (!run_reg)
      begin
         fsp_next = 1'b1;
      end
      else if (scan_end && fsp_reg)
      begin
         fsp_next = 1'b0;
         fsp_done_next = 1'b1;
      end
      // status refreshed once per scan
      if (scan_end)
      begin
         stat_scan_next = stat_sync_reg;
      end
   end

   // error flags; a set wins over a same-cycle clear
   always_comb
   begin
      diag_next = diag_reg | diag_error;
      live_next = instr_error;
      sticky_next = sticky_reg;
      step_next = step_reg;
      if (wr && wb_adr_i == PSRB_ADDR_SYSFLAG && wb_sel_i[0])
      begin
         if (wb_dat_i[PSRB_SF_STICKY])
         begin
            sticky_next = 1'b0;
         end
         if (wb_dat_i[PSRB_SF_DIAG])
         begin
            diag_next = diag_error;
         end
      end
      if (instr_error)
      begin
         sticky_next = 1'b1;
      end
      if (instr_error && !sticky_reg)
      begin
         step_next = instr_error_step; // capture only on rise
      end
   end

   // terminal source mux, whole group switched together
   always_comb
   begin
      if (ctrl_reg[PSRB_CTRL_SRC])
      begin
         term_next = term_word_reg[PSRB_TERM_BITS-1:0];
      end
      else
      begin
         term_next = ctrl_reg[PSRB_TERM_BITS-1:0];
      end
   end

   // read mux; unmapped reads return zero, still acked
   always_comb
   begin
      ack_next = req;
      rd_mem_next = req & mem_hit;
      rdat_next = PSRB_RST_WORD;
      case (wb_adr_i)
         PSRB_ADDR_RELAY_LO: rdat_next = relay_lo_reg;
         PSRB_ADDR_RELAY_HI: rdat_next = relay_hi_reg;
         PSRB_ADDR_SYSFLAG: rdat_next = 32'({first_scan_pulse_n, first_scan_pulse,
            1'b0, 1'b1, sticky_reg, live_reg, diag_reg});
         PSRB_ADDR_CTRL: rdat_next = 32'(ctrl_reg);
         PSRB_ADDR_TERM_WORD: rdat_next = 32'(term_word_reg);
         PSRB_ADDR_STATUS: rdat_next = 32'(stat_scan_reg);
         PSRB_ADDR_ERR_STEP: rdat_next = 32'(step_reg);
         PSRB_ADDR_RUN: rdat_next = 32'(run_reg);
         default: rdat_next = PSRB_RST_WORD;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge ref_clk)
   begin
      stat_meta_reg <= stat_meta_next;
      stat_sync_reg <= stat_sync_next;
      if (sys_rst)
      begin
         ack_reg <= 1'b0;
         rdat_reg <= PSRB_RST_WORD;
         rd_mem_reg <= 1'b0;
         relay_lo_reg <= PSRB_RST_WORD;
         relay_hi_reg <= PSRB_RST_WORD;
         ctrl_reg <= 13'(PSRB_RST_WORD);
         term_word_reg <= PSRB_RST_HALF;
         run_reg <= 1'b0;
         live_reg <= 1'b0;
         sticky_reg <= 1'b0;
         diag_reg <= 1'b0;
         step_reg <= PSRB_RST_HALF;
         fsp_reg <= 1'b0;
         fsp_done_reg <= 1'b0;
         term_reg <= PSRB_RST_TERM;
         stat_scan_reg <= 20'(PSRB_RST_WORD);
      end
      else
      begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
         rd_mem_reg <= rd_mem_next;
         relay_lo_reg <= relay_lo_next;
         relay_hi_reg <= relay_hi_next;
         ctrl_reg <= ctrl_next;
         term_word_reg <= term_word_next;
         run_reg <= run_next;
         live_reg <= live_next;
         sticky_reg <= sticky_next;
         diag_reg <= diag_next;
         step_reg <= step_next;
         fsp_reg <= fsp_next;
         fsp_done_reg <= fsp_done_next;
         term_reg <= term_next;
         stat_scan_reg <= stat_scan_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rd_mem_reg ? 32'(mem_rdata) : rdat_reg;
   // terminals from term_reg, the selected source registered one cycle after the mux
   assign forward_start = term_reg[0];
   assign reverse_start = term_reg[1];
   assign speed_sel_high = term_reg[2];
   assign speed_sel_mid = term_reg[3];
   assign speed_sel_low = term_reg[4];
   assign inch_mode_sel = term_reg[5];
   assign second_function_sel = term_reg[6];
   assign current_input_sel = term_reg[7];
   assign changeover_sel = term_reg[8];
   assign output_shutoff = term_reg[9];
   assign self_hold_sel = term_reg[10];
   assign drive_reset_in = term_reg[11];
   assign self_diag_error_flag = diag_reg;
   assign live_op_error_flag = live_reg;
   assign sticky_op_error_flag = sticky_reg;
   // constant flags ignore run/stop
   assign always_one_flag = 1'b1;
   assign always_zero_flag = 1'b0;
   // stopped: pulse low, inverted low; first scan: 1/0; later: 0/1
   assign first_scan_pulse = fsp_reg;
   assign first_scan_pulse_n = fsp_done_reg;
endmodule // psrb_relay_bank
`default_nettype wire

// File: hdl/psrb_pkg.sv
package psrb_pkg;
   // wishbone register map, byte addresses of 32-bit words
   localparam logic [7:0] PSRB_ADDR_RELAY_LO = 8'h00;
   localparam logic [7:0] PSRB_ADDR_RELAY_HI = 8'h04;
   localparam logic [7:0] PSRB_ADDR_SYSFLAG = 8'h08;
   localparam logic [7:0] PSRB_ADDR_CTRL = 8'h0c;
   localparam logic [7:0] PSRB_ADDR_TERM_WORD = 8'h10;
   localparam logic [7:0] PSRB_ADDR_STATUS = 8'h14;
   localparam logic [7:0] PSRB_ADDR_ERR_STEP = 8'h18;
   localparam logic [7:0] PSRB_ADDR_RUN = 8'h1c;
   localparam logic [7:0] PSRB_ADDR_DATA_BASE = 8'h80;
   // user data words 100..119 sit at data base + 4*(n-100)
   localparam int PSRB_DATA_FIRST = 100;
   localparam int PSRB_DATA_WORDS = 20;
   localparam int PSRB_DATA_AW = 5;
   // system flag word bit positions
   localparam int PSRB_SF_DIAG = 0;
   localparam int PSRB_SF_LIVE = 1;
   localparam int PSRB_SF_STICKY = 2;
   localparam int PSRB_SF_ONE = 3;
   localparam int PSRB_SF_ZERO = 4;
   localparam int PSRB_SF_FSP = 5;
   localparam int PSRB_SF_FSPN = 6;
   // control word: terminal bits 11:0, source select bit 12
   localparam int PSRB_TERM_BITS = 12;
   localparam int PSRB_CTRL_SRC = 12;
   // run word: bit0 run/stop, bit1 scan end strobe (write-only)
   localparam int PSRB_RUN_BIT = 0;
   localparam int PSRB_SCAN_END_BIT = 1;
   localparam int PSRB_STATUS_BITS = 20;
   localparam logic [31:0] PSRB_RST_WORD = 32'h0000_0000;
   localparam logic [15:0] PSRB_RST_HALF = 16'h0000;
   localparam logic [11:0] PSRB_RST_TERM = 12'h000;
endpackage

// File: hdl/psrb_data_mem.sv
`timescale 1ns/1ps
`default_nettype none
module psrb_data_mem
(
   input wire logic ref_clk,
   input wire logic we,
   input wire logic [psrb_pkg::PSRB_DATA_AW-1:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);
   import psrb_pkg::*;
   logic [15:0] mem_reg [0:PSRB_DATA_WORDS-1];
   logic [15:0] rdata_reg;

   // registered read; memory contents are not reset, like user ram
   always_ff @(posedge ref_clk)
   begin
      if (we)
      begin
         mem_reg[addr] <= wdata;
      end
      rdata_reg <= mem_reg[addr];
   end
   assign rdata = rdata_reg;
endmodule // psrb_data_mem
`default_nettype wire

// File: dv/psrb_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// drive side: running and direction follow the start terminals
module psrb_drive_model
(
   input wire logic forward_start,
   input wire logic reverse_start,
   input wire logic [19:0] cond,
   output logic [8:0] drive_status_in,
   output logic [10:0] virtual_out_in
);
   // other status bits and virtual outputs come from the bench's scenario
   assign drive_status_in = {cond[8:3], reverse_start, forward_start,
      forward_start | reverse_start};
   assign virtual_out_in = cond[19:9]; // no output card fitted
endmodule // psrb_drive_model
`default_nettype wire

// File: dv/psrb_relay_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
module psrb_relay_bank_properties
   import psrb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic diag_error,
   input wire logic instr_error,
   input wire logic forward_start,
   input wire logic drive_reset_in,
   input wire logic self_diag_error_flag,
   input wire logic live_op_error_flag,
   input wire logic sticky_op_error_flag,
   input wire logic always_one_flag,
   input wire logic always_zero_flag,
   input wire logic first_scan_pulse,
   input wire logic first_scan_pulse_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // a request is taken on an edge with cyc and stb high and no ack
   logic take;
   logic clr;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign clr = take && wb_we_i && wb_adr_i == PSRB_ADDR_SYSFLAG && wb_sel_i[0] && wb_dat_i[2];
   sequence run_wr;
      take && wb_we_i && wb_adr_i == PSRB_ADDR_RUN && wb_sel_i[0];
   endsequence
   sequence stopped;
      !first_scan_pulse && !first_scan_pulse_n;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_const_flags: assert property (always_one_flag && !always_zero_flag)
      else $error("constant flags wrong");
   a_diag_set: assert property (diag_error |=> self_diag_error_flag)
      else $error("diag flag not set");
   a_live_follow: assert property (!$past(sys_rst)
      |-> live_op_error_flag == $past(instr_error))
      else $error("live flag off its cause");
   a_sticky_set: assert property (instr_error |=> sticky_op_error_flag)
      else $error("sticky flag not set");
   a_sticky_hold: assert property (sticky_op_error_flag && !clr |=> sticky_op_error_flag)
      else $error("sticky flag lost");
   a_sticky_cause: assert property (!sticky_op_error_flag && !instr_error
      |=> !sticky_op_error_flag)
      else $error("sticky flag without error");
   a_scan_entry: assert property (run_wr ##0 (wb_dat_i[1:0] == 2'b01) ##0 stopped
      |-> ##[1:2] first_scan_pulse && !first_scan_pulse_n)
      else $error("no first scan on run");
   a_scan_end: assert property (run_wr ##0 (wb_dat_i[1:0] == 2'b11 && first_scan_pulse)
      |-> ##[1:2] !first_scan_pulse && first_scan_pulse_n)
      else $error("first scan did not end");
   a_scan_stop: assert property (run_wr ##0 !wb_dat_i[0] |-> ##[1:2] stopped)
      else $error("flags not stopped");
   a_term_still: assert property (!$past(take) && !$past(take, 2)
      |-> $stable({forward_start, drive_reset_in}))
      else $error("terminal moved without a write");
endmodule // psrb_relay_bank_properties
bind psrb_relay_bank psrb_relay_bank_properties u_prop (.*);
`default_nettype wire

// File: dv/psrb_relay_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module psrb_relay_bank_bench;
   import psrb_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] rd;
   logic diag = 1'b0;
   logic ierr = 1'b0;
   logic [15:0] step = 16'h0;
   logic [19:0] cond = 20'h0;
   wire [31:0] dat_o;
   wire ack;
   wire [8:0] dstat;
   wire [10:0] vout;
   wire [11:0] term;
   wire [6:0] flg;
   int fails = 0;
   int cmp_count = 0;
   // free-running clock, 4 ns period
   always #2 ref_clk = ~ref_clk;
   psrb_relay_bank dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .diag_error(diag), .instr_error(ierr), .instr_error_step(step),
      .drive_status_in(dstat), .virtual_out_in(vout), .forward_start(term[0]),
      .reverse_start(term[1]), .speed_sel_high(term[2]), .speed_sel_mid(term[3]),
      .speed_sel_low(term[4]), .inch_mode_sel(term[5]), .second_function_sel(term[6]),
      .current_input_sel(term[7]), .changeover_sel(term[8]), .output_shutoff(term[9]),
      .self_hold_sel(term[10]), .drive_reset_in(term[11]), .self_diag_error_flag(flg[0]),
      .live_op_error_flag(flg[1]), .sticky_op_error_flag(flg[2]), .always_one_flag(flg[3]),
      .always_zero_flag(flg[4]), .first_scan_pulse(flg[5]), .first_scan_pulse_n(flg[6]));
   psrb_drive_model u_drive (.forward_start(term[0]), .reverse_start(term[1]), .cond(cond),
      .drive_status_in(dstat), .virtual_out_in(vout));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; held until ack is sampled, no latency assumed
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do @(posedge ref_clk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hf);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0, 4'hf);
      chk(rd, exp);
      // flag pins must agree with the flag word while it is read
      if (a == PSRB_ADDR_SYSFLAG)
      begin
         chk(32'(flg), exp);
      end
   endtask
   task automatic err(input logic [15:0] s);
      @(posedge ref_clk);
      ierr <= 1'b1;
      step <= s;
      @(posedge ref_clk);
      ierr <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #40000;
      fails++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rdc(PSRB_ADDR_SYSFLAG, 32'h8);
      wr(PSRB_ADDR_RELAY_LO, 32'ha5a5_5a5a);
      wr(PSRB_ADDR_RELAY_HI, 32'hffff_0001);
      wb(1'b1, PSRB_ADDR_RELAY_LO, 32'h0000_00ff, 4'h1);
      rdc(PSRB_ADDR_RELAY_LO, 32'ha5a5_5aff);
      rdc(PSRB_ADDR_RELAY_HI, 32'hffff_0001);
      rdc(8'h60, 32'h0);
      $display("test relays done");
      for (int i = 0; i < PSRB_DATA_WORDS; i++)
         wr(PSRB_ADDR_DATA_BASE + 8'(4 * i), 32'h0000_c000 + i);
      for (int i = 0; i < PSRB_DATA_WORDS; i++)
      begin
         wb(1'b0, PSRB_ADDR_DATA_BASE + 8'(4 * i), 32'h0, 4'hf);
         chk(32'(rd[15:0]), 32'h0000_c000 + i);
      end
      // a data word write without both low lanes must leave the word alone
      wb(1'b1, PSRB_ADDR_DATA_BASE, 32'h0000_ffff, 4'h1);
      wb(1'b0, PSRB_ADDR_DATA_BASE, 32'h0, 4'hf);
      chk(32'(rd[15:0]), 32'h0000_c000);
      $display("test memory done");
      for (int i = 0; i < PSRB_TERM_BITS; i++)
      begin
         wr(PSRB_ADDR_CTRL, 32'(1) << i);
         repeat (2) @(posedge ref_clk);
         chk(32'(term), 32'(1) << i);
      end
      wr(PSRB_ADDR_TERM_WORD, 32'h5a3);
      wr(PSRB_ADDR_CTRL, 32'h10ff);
      repeat (2) @(posedge ref_clk);
      chk(32'(term), 32'h5a3);
      wr(PSRB_ADDR_CTRL, 32'h0001);
      repeat (2) @(posedge ref_clk);
      chk(32'(term), 32'h001);
      rdc(PSRB_ADDR_CTRL, 32'h0000_0001);
      rdc(PSRB_ADDR_TERM_WORD, 32'h0000_05a3);
      $display("test terminals done");
      cond <= 20'hb5a38;
      wr(PSRB_ADDR_RUN, 32'h1);
      rdc(PSRB_ADDR_SYSFLAG, 32'h28);
      wr(PSRB_ADDR_RUN, 32'h3);
      rdc(PSRB_ADDR_SYSFLAG, 32'h48);
      rdc(PSRB_ADDR_STATUS, {12'h0, cond[19:3], 3'b011});
      wr(PSRB_ADDR_RUN, 32'h0);
      rdc(PSRB_ADDR_SYSFLAG, 32'h08);
      wr(PSRB_ADDR_RUN, 32'h1);
      rdc(PSRB_ADDR_SYSFLAG, 32'h28);
      rdc(PSRB_ADDR_RUN, 32'h1);
      $display("test scan done");
      @(posedge ref_clk);
      ierr <= 1'b1;
      step <= 16'h0123;
      rdc(PSRB_ADDR_SYSFLAG, 32'h2e);
      @(posedge ref_clk);
      ierr <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rdc(PSRB_ADDR_SYSFLAG, 32'h2c);
      err(16'h0456);
      rdc(PSRB_ADDR_ERR_STEP, 32'h0123);
      wr(PSRB_ADDR_SYSFLAG, 32'h4); // only the clear bit is touched
      rdc(PSRB_ADDR_SYSFLAG, 32'h28);
      err(16'h0789);
      rdc(PSRB_ADDR_ERR_STEP, 32'h0789);
      $display("test errors done");
      @(posedge ref_clk);
      diag <= 1'b1;
      @(posedge ref_clk);
      diag <= 1'b0;
      rdc(PSRB_ADDR_SYSFLAG, 32'h2d);
      wr(PSRB_ADDR_SYSFLAG, 32'h5);
      rdc(PSRB_ADDR_SYSFLAG, 32'h28);
      $display("test diag done");
      wrap_up();
   end
endmodule // psrb_relay_bank_bench
`default_nettype wire
